// *** verilog/hcw_transmit_control.sv ***
/*
 Transmit control of a code hopping encoder: button decode, counter choice,
 code word assembly, frame sequencing, auto shutoff, IR carrier, word blanking,
 with an Avalon-MM register slave. Assumes the cipher sits outside: software
 reads the plaintext block and writes back the hop word. Buttons are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - time-out reached with shutoff enabled forces data output low and LED off
// - time-out state holds until every button input is low again
// - shutoff disabled means words repeat for as long as a button is held
// - time-out limit is 256 words at slow rate, 512 at fast rate
// - dual counter mode: codes 1-7 use counter A, codes 8-15 counter B
// - dual counter mode off: counter A serves every function code
// - dual counter mode also gates data output with a 40 kHz carrier from the system clock
// - seed enabled: code 9 sends seed at once, code 3 after the delay
// - frame is preamble, header, encrypted part, fixed part, then guard period
// - payload is 67 bits, 32 encrypted then 35 fixed
// - plaintext holds function, user bits, wrap, mode, serial low byte, counter
// - normal fixed part: low voltage bit, 2 check bits, function, 28-bit serial
// - long serial mode sends full 32-bit serial and drops the function bits
// - a released button never cuts the current word short
// - each activation sends at least two full words outside skip mode, where only the first of the two is emitted
// - words repeat while held; stop after a word ending with button released
// - a different button during a word aborts it and starts a fresh word
// - skip mode emits only every second word, output idle in skipped ones
// - bit rate select picks the faster rate when set, slower when clear
module hcw_transmit_control #(
   parameter int ELEM_UNIT_CYCLES = hcw_pkg::ELEM_UNIT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic button_in_0,
   input wire logic button_in_1,
   input wire logic button_in_2,
   input wire logic button_in_3,
   input wire logic low_voltage,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic data_out,
   output logic led_n,
   output logic power_up
);

   function automatic logic use_counter_b(input logic dual, input logic [3:0] f);
      return dual && (f >= hcw_pkg::FUNC_B_FIRST);
   endfunction

   // format bit only shortens the element in the plain width-coded format
   function automatic logic [15:0] elem_len(input logic fmt, input logic rate, input logic vpwm);
      logic [2:0] mul;
      logic fast_fmt;
      fast_fmt = fmt && !vpwm;
      if (fast_fmt && rate) begin
         mul = hcw_pkg::ELEM_MUL_FAST;
      end else if (fast_fmt || rate) begin
         mul = hcw_pkg::ELEM_MUL_MID;
      end else begin
         mul = hcw_pkg::ELEM_MUL_SLOW;
      end
      return 16'(int'(mul) * ELEM_UNIT_CYCLES);
   endfunction

   logic [hcw_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [31:0] serial_r, serial_nxt;
   logic [31:0] hop_r, hop_nxt;
   logic [31:0] seed_r, seed_nxt;
   logic [15:0] sync_a_r, sync_a_nxt;
   logic [15:0] sync_b_r, sync_b_nxt;
   logic waitreq_r, waitreq_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   hcw_pkg::hcw_state_e state_r, state_nxt;
   logic [15:0] elem_cnt_r, elem_cnt_nxt;
   logic [6:0] seg_cnt_r, seg_cnt_nxt;
   logic [1:0] phase_r, phase_nxt;
   logic [66:0] word_r, word_nxt;
   logic [9:0] words_r, words_nxt;
   logic [3:0] func_r, func_nxt;
   logic [9:0] carrier_r, carrier_nxt;
   logic data_out_r, data_out_nxt;
   logic led_n_r, led_n_nxt;
   logic power_r, power_nxt;

   logic [3:0] buttons;
   logic auto_off, dual, skip, rate;
   logic [15:0] elem_cycles;
   logic elem_tick, seg_end, active, abort, start_seq;
   logic [9:0] limit, delay_words, words_inc;
   logic load_word, seed_send, line, fire;
   logic [3:0] load_func;
   logic [31:0] enc_part, fixed_part, plain;

   assign buttons = {button_in_3, button_in_2, button_in_1, button_in_0};
   assign auto_off = ctrl_r[hcw_pkg::CB_AUTO_OFF];
   assign dual = ctrl_r[hcw_pkg::CB_DUAL];
   assign skip = ctrl_r[hcw_pkg::CB_SKIP];
   assign rate = ctrl_r[hcw_pkg::CB_RATE];
   assign elem_cycles = elem_len(ctrl_r[hcw_pkg::CB_FMT], rate, ctrl_r[hcw_pkg::CB_MODULATION]);
   assign limit = rate ? hcw_pkg::TIMEOUT_WORDS_FAST : hcw_pkg::TIMEOUT_WORDS_SLOW;
   assign delay_words = rate ? hcw_pkg::DELAY_WORDS_FAST : hcw_pkg::DELAY_WORDS_SLOW;
   assign plain = {func_r, ctrl_r[hcw_pkg::CB_USR_LO +: 2], ctrl_r[hcw_pkg::CB_WRAP], dual, serial_r[7:0],
                   use_counter_b(dual, func_r) ? sync_b_r : sync_a_r};
   assign fire = (avs_read || avs_write) && !waitreq_r;

   // register file and synchronisation counters
   always_comb begin
      ctrl_nxt = ctrl_r;
      serial_nxt = serial_r;
      hop_nxt = hop_r;
      seed_nxt = seed_r;
      sync_a_nxt = sync_a_r;
      sync_b_nxt = sync_b_r;
      rdata_nxt = rdata_r;
      // one wait cycle, so read data are settled before waitrequest drops
      waitreq_nxt = !((avs_read || avs_write) && waitreq_r);
      if ((avs_read || avs_write) && waitreq_r) begin
         case (avs_address)
            hcw_pkg::REG_CTRL: rdata_nxt = {19'h00000, ctrl_r};
            hcw_pkg::REG_SERIAL: rdata_nxt = serial_r;
            hcw_pkg::REG_HOP: rdata_nxt = hop_r;
            hcw_pkg::REG_SEED: rdata_nxt = seed_r;
            hcw_pkg::REG_SYNC_A: rdata_nxt = {16'h0000, sync_a_r};
            hcw_pkg::REG_SYNC_B: rdata_nxt = {16'h0000, sync_b_r};
            hcw_pkg::REG_STATUS: rdata_nxt = {14'h0000, words_r, func_r, 1'b0, state_r};
            hcw_pkg::REG_PLAIN: rdata_nxt = plain;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      if (fire && avs_write) begin
         case (avs_address)
            hcw_pkg::REG_CTRL: ctrl_nxt = avs_writedata[hcw_pkg::CTRL_W-1:0];
            hcw_pkg::REG_SERIAL: serial_nxt = avs_writedata;
            hcw_pkg::REG_HOP: hop_nxt = avs_writedata;
            hcw_pkg::REG_SEED: seed_nxt = avs_writedata;
            hcw_pkg::REG_SYNC_A: sync_a_nxt = avs_writedata[15:0];
            hcw_pkg::REG_SYNC_B: sync_b_nxt = avs_writedata[15:0];
            default: ;
         endcase
      end
      // hardware advance wins over a software write in the same cycle
      if (start_seq) begin
         if (use_counter_b(dual, load_func)) begin
            sync_b_nxt = sync_b_r + 16'h0001;
         end else begin
            sync_a_nxt = sync_a_r + 16'h0001;
            if (sync_a_r == hcw_pkg::SYNC_MAX) begin
               ctrl_nxt[hcw_pkg::CB_WRAP] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ctrl_r <= hcw_pkg::CTRL_RESET;
         serial_r <= hcw_pkg::WORD_RESET;
         hop_r <= hcw_pkg::WORD_RESET;
         seed_r <= hcw_pkg::WORD_RESET;
         sync_a_r <= hcw_pkg::SYNC_RESET;
         sync_b_r <= hcw_pkg::SYNC_RESET;
         waitreq_r <= 1'b1;
         rdata_r <= hcw_pkg::WORD_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
         serial_r <= serial_nxt;
         hop_r <= hop_nxt;
         seed_r <= seed_nxt;
         sync_a_r <= sync_a_nxt;
         sync_b_r <= sync_b_nxt;
         waitreq_r <= waitreq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // frame sequencer
   always_comb begin
      state_nxt = state_r;
      seg_cnt_nxt = seg_cnt_r;
      phase_nxt = phase_r;
      word_nxt = word_r;
      words_nxt = words_r;
      func_nxt = func_r;
      load_word = 1'b0;
      load_func = func_r;
      words_inc = words_r + 10'h001;
      carrier_nxt = (carrier_r == hcw_pkg::CARRIER_LAST) ? 10'h000 : carrier_r + 10'h001;
      active = (state_r != hcw_pkg::ST_IDLE) && (state_r != hcw_pkg::ST_TIMEOUT);
      elem_tick = active && (elem_cnt_r == elem_cycles - 16'h0001);
      elem_cnt_nxt = (!active || elem_tick) ? 16'h0000 : elem_cnt_r + 16'h0001;
      abort = active && (buttons != hcw_pkg::FUNC_NONE) && (buttons != func_r);
      start_seq = abort || ((state_r == hcw_pkg::ST_IDLE) && (buttons != hcw_pkg::FUNC_NONE));
      seg_end = 1'b0;
      case (state_r)
         hcw_pkg::ST_PREAMBLE: seg_end = seg_cnt_r == hcw_pkg::PREAMBLE_ELEMS - 7'h01;
         hcw_pkg::ST_HEADER: seg_end = seg_cnt_r == hcw_pkg::HEADER_ELEMS - 7'h01;
         hcw_pkg::ST_GUARD: seg_end = seg_cnt_r == hcw_pkg::GUARD_ELEMS - 7'h01;
         default: seg_end = 1'b0;
      endcase
      case (state_r)
         hcw_pkg::ST_IDLE: ;
         hcw_pkg::ST_PREAMBLE, hcw_pkg::ST_HEADER: begin
            if (elem_tick) begin
               seg_cnt_nxt = seg_end ? 7'h00 : seg_cnt_r + 7'h01;
               if (seg_end) begin
                  state_nxt = (state_r == hcw_pkg::ST_PREAMBLE) ? hcw_pkg::ST_HEADER : hcw_pkg::ST_DATA;
                  phase_nxt = 2'h0;
               end
            end
         end
         hcw_pkg::ST_DATA: begin
            // buttons are not looked at here, so a release finishes the word
            if (elem_tick) begin
               phase_nxt = phase_r + 2'h1;
               if (phase_r == hcw_pkg::BIT_PHASES - 2'h1) begin
                  phase_nxt = 2'h0;
                  word_nxt = word_r >> 1;
                  seg_cnt_nxt = seg_cnt_r + 7'h01;
                  if (seg_cnt_r == hcw_pkg::WORD_BITS - 7'h01) begin
                     state_nxt = hcw_pkg::ST_GUARD;
                     seg_cnt_nxt = 7'h00;
                  end
               end
            end
         end
         hcw_pkg::ST_GUARD: begin
            if (elem_tick) begin
               seg_cnt_nxt = seg_end ? 7'h00 : seg_cnt_r + 7'h01;
               if (seg_end) begin
                  words_nxt = words_inc;
                  if (auto_off && words_inc >= limit) begin
                     state_nxt = hcw_pkg::ST_TIMEOUT;
                  end else if (buttons != hcw_pkg::FUNC_NONE || words_inc < hcw_pkg::MIN_WORDS) begin
                     state_nxt = hcw_pkg::ST_PREAMBLE;
                     load_word = 1'b1;
                  end else begin
                     state_nxt = hcw_pkg::ST_IDLE;
                  end
               end
            end
         end
         hcw_pkg::ST_TIMEOUT: begin
            if (buttons == hcw_pkg::FUNC_NONE) begin
               state_nxt = hcw_pkg::ST_IDLE;
            end
         end
         default: state_nxt = hcw_pkg::ST_IDLE;
      endcase
      if (start_seq) begin
         state_nxt = hcw_pkg::ST_PREAMBLE;
         seg_cnt_nxt = 7'h00;
         phase_nxt = 2'h0;
         elem_cnt_nxt = 16'h0000;
         words_nxt = 10'h000;
         func_nxt = buttons;
         load_func = buttons;
         load_word = 1'b1;
      end
      seed_send = ctrl_r[hcw_pkg::CB_SEED] && ((load_func == hcw_pkg::FUNC_SEED_NOW) ||
                  ((load_func == hcw_pkg::FUNC_SEED_LATE) && (words_nxt >= delay_words)));
      enc_part = seed_send ? seed_r : hop_r;
      fixed_part = ctrl_r[hcw_pkg::CB_LONG_SER] ? serial_r : {load_func, serial_r[27:0]};
      if (load_word) begin
         word_nxt = {ctrl_r[hcw_pkg::CB_CRC_LO +: 2], low_voltage, fixed_part, enc_part};
      end
      // width-coded bit: high, then inverted data, then low
      case (state_r)
         hcw_pkg::ST_PREAMBLE: line = !seg_cnt_r[0];
         hcw_pkg::ST_DATA: line = (phase_r == 2'h0) || ((phase_r == 2'h1) && !word_r[0]);
         default: line = 1'b0;
      endcase
      data_out_nxt = line && !(skip && words_r[0]) &&
                     (!dual || (carrier_r < hcw_pkg::CARRIER_HALF));
      led_n_nxt = !(state_r == hcw_pkg::ST_PREAMBLE || state_r == hcw_pkg::ST_HEADER ||
                    state_r == hcw_pkg::ST_DATA);
      power_nxt = state_r != hcw_pkg::ST_IDLE;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_r <= hcw_pkg::ST_IDLE;
         elem_cnt_r <= 16'h0000;
         seg_cnt_r <= 7'h00;
         phase_r <= 2'h0;
         word_r <= 67'h0;
         words_r <= 10'h000;
         func_r <= 4'h0;
         carrier_r <= 10'h000;
         data_out_r <= 1'b0;
         led_n_r <= 1'b1;
         power_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         elem_cnt_r <= elem_cnt_nxt;
         seg_cnt_r <= seg_cnt_nxt;
         phase_r <= phase_nxt;
         word_r <= word_nxt;
         words_r <= words_nxt;
         func_r <= func_nxt;
         carrier_r <= carrier_nxt;
         data_out_r <= data_out_nxt;
         led_n_r <= led_n_nxt;
         power_r <= power_nxt;
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = waitreq_r;
   assign data_out = data_out_r;
   assign led_n = led_n_r;
   assign power_up = power_r;

   AST_TIMEOUT_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_r == hcw_pkg::ST_TIMEOUT |=> !data_out && led_n)
      else $error("output active during time-out");

   AST_TIMEOUT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_r == hcw_pkg::ST_TIMEOUT && buttons != 4'h0 |=> state_r == hcw_pkg::ST_TIMEOUT)
      else $error("time-out left while a button is held");

   AST_NO_SHUTOFF: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_r != hcw_pkg::ST_TIMEOUT && !auto_off |=> state_r != hcw_pkg::ST_TIMEOUT)
      else $error("time-out entered with shutoff disabled");

   AST_LIMIT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_r == hcw_pkg::ST_GUARD && elem_tick && seg_end && auto_off && !abort &&
      words_r == limit - 10'h001 |=> state_r == hcw_pkg::ST_TIMEOUT)
      else $error("time-out not taken at the word limit");

   AST_COUNTER_B: assert property (@(posedge sys_clk) disable iff (!rst_b)
      start_seq && dual && buttons >= 4'h8 |=> sync_b_r == $past(sync_b_r) + 16'h0001)
      else $error("second counter not advanced");

   AST_SINGLE_COUNTER: assert property (@(posedge sys_clk) disable iff (!rst_b)
      start_seq && !dual && !fire |=> sync_a_r == $past(sync_a_r) + 16'h0001 && $stable(sync_b_r))
      else $error("wrong counter advanced");

   AST_CARRIER: assert property (@(posedge sys_clk) disable iff (!rst_b)
      dual && carrier_r >= hcw_pkg::CARRIER_HALF |=> !data_out)
      else $error("output high in carrier off half");

   AST_MIN_TWO: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_r == hcw_pkg::ST_GUARD && elem_tick && seg_end && words_r == 10'h000 |=>
      state_r == hcw_pkg::ST_PREAMBLE)
      else $error("stopped before two words");

   AST_COMPLETE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state_r == hcw_pkg::ST_DATA && buttons == 4'h0 |=>
      state_r == hcw_pkg::ST_DATA || state_r == hcw_pkg::ST_GUARD)
      else $error("word cut short on release");

   AST_ABORT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      abort |=> state_r == hcw_pkg::ST_PREAMBLE && func_r == $past(buttons) && words_r == 10'h000)
      else $error("abort did not restart the word");

   AST_BLANK: assert property (@(posedge sys_clk) disable iff (!rst_b)
      skip && words_r[0] ##1 skip && words_r[0] |-> !data_out)
      else $error("output active in a skipped word");

endmodule
`default_nettype wire

// *** verilog/hcw_pkg.sv ***
/*
 Constants for the code word transmit control: register map, control fields,
 frame segment lengths and timing counts. Assumes a 40 MHz system clock.
*/
`default_nettype none
package hcw_pkg;
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int ELEM_UNIT_US = 100;
   localparam int ELEM_UNIT_CYC = (CLK_HZ / 1_000_000) * ELEM_UNIT_US;
   localparam int CARRIER_HZ = 40_000;
   localparam int CARRIER_CYC = CLK_HZ / CARRIER_HZ;
   localparam logic [9:0] CARRIER_HALF = 10'(CARRIER_CYC / 2);
   localparam logic [9:0] CARRIER_LAST = 10'(CARRIER_CYC - 1);
   localparam logic [2:0] ELEM_MUL_SLOW = 3'h4;
   localparam logic [2:0] ELEM_MUL_MID = 3'h2;
   localparam logic [2:0] ELEM_MUL_FAST = 3'h1;
   // frame segments, in basic elements; data word in bits of three elements each
   localparam logic [6:0] PREAMBLE_ELEMS = 7'h17;
   localparam logic [6:0] HEADER_ELEMS = 7'h0A;
   localparam logic [6:0] GUARD_ELEMS = 7'h27;
   localparam logic [6:0] WORD_BITS = 7'h43;
   localparam logic [1:0] BIT_PHASES = 2'h3;
   // word counts
   localparam logic [9:0] TIMEOUT_WORDS_SLOW = 10'h100;
   localparam logic [9:0] TIMEOUT_WORDS_FAST = 10'h200;
   localparam logic [9:0] DELAY_WORDS_SLOW = 10'h01C;
   localparam logic [9:0] DELAY_WORDS_FAST = 10'h038;
   localparam logic [9:0] MIN_WORDS = 10'h002;
   // function codes
   localparam logic [3:0] FUNC_NONE = 4'h0;
   localparam logic [3:0] FUNC_SEED_NOW = 4'h9;
   localparam logic [3:0] FUNC_SEED_LATE = 4'h3;
   localparam logic [3:0] FUNC_B_FIRST = 4'h8;
   // register byte offsets
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_SERIAL = 5'h04;
   localparam logic [4:0] REG_HOP = 5'h08;
   localparam logic [4:0] REG_SEED = 5'h0C;
   localparam logic [4:0] REG_SYNC_A = 5'h10;
   localparam logic [4:0] REG_SYNC_B = 5'h14;
   localparam logic [4:0] REG_STATUS = 5'h18;
   localparam logic [4:0] REG_PLAIN = 5'h1C;
   // control field positions
   localparam int CB_AUTO_OFF = 0;
   localparam int CB_DUAL = 1;
   localparam int CB_SKIP = 2;
   localparam int CB_RATE = 3;
   localparam int CB_FMT = 4;
   localparam int CB_MODULATION = 5;
   localparam int CB_LONG_SER = 6;
   localparam int CB_WRAP = 7;
   localparam int CB_SEED = 8;
   localparam int CB_USR_LO = 9;
   localparam int CB_CRC_LO = 11;
   localparam int CTRL_W = 13;
   localparam logic [12:0] CTRL_RESET = 13'h0000;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [15:0] SYNC_RESET = 16'h0000;
   localparam logic [15:0] SYNC_MAX = 16'hFFFF;
   typedef enum logic [2:0] {ST_IDLE, ST_PREAMBLE, ST_HEADER, ST_DATA, ST_GUARD, ST_TIMEOUT} hcw_state_e;
endpackage
`default_nettype wire

// *** verif/hcw_rx_model.sv ***
/*
 Receiver model for the code word transmit control: finds the header gap on the
 data line and decodes 67 bits, LSB first. Assumes plain (no carrier) output and
 a fixed basic element of ELEM_CYC clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module hcw_rx_model #(
   parameter int ELEM_CYC = 4
) (
   input wire logic sys_clk,
   input wire logic data_in,
   output logic [66:0] rx_word,
   output logic [15:0] rx_count
);
   int low;
   logic hit;
   initial begin
      rx_count = 16'h0000;
      rx_word = '0;
      forever begin
         // header gap is 10 elements; guard and idle are longer, bit lows shorter
         low = 0;
         hit = 1'b0;
         do begin
            @(posedge sys_clk);
            if (data_in !== 1'b1) low++;
            else if (low >= 9 * ELEM_CYC && low <= 11 * ELEM_CYC) hit = 1'b1;
            else low = 0;
         end while (!hit);
         // each bit: high, inverted bit, low; sample mid second element
         for (int i = 0; i < 67; i++) begin
            repeat (ELEM_CYC + ELEM_CYC / 2) @(posedge sys_clk);
            rx_word[i] = ~data_in;
            repeat (2 * ELEM_CYC - ELEM_CYC / 2) @(posedge sys_clk);
         end
         rx_count = rx_count + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// *** verif/hcw_transmit_control_test.sv ***
/*
 Self-checking bench for the code word transmit control: Avalon-MM register
 tasks, button sequences and a receiver model. Assumes short timing parameter.
*/
`timescale 1ns/1ps
`default_nettype none
module hcw_transmit_control_test;
   localparam int TEU = 4;
   localparam logic [31:0] SER = 32'hA5C3_1E7B;
   localparam logic [31:0] HOP = 32'h1234_5678;
   localparam logic [31:0] SEED = 32'h0F1E_2D3C;
   logic sys_clk, rst_b, low_voltage, avs_read, avs_write, avs_waitrequest;
   logic data_out, led_n, power_up;
   logic [3:0] btn;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [66:0] rx_word;
   logic [15:0] rx_count, base;
   int err_total, comparisons;
   hcw_transmit_control #(.ELEM_UNIT_CYCLES(TEU)) i_hcw_transmit_control (
      .sys_clk(sys_clk), .rst_b(rst_b), .button_in_0(btn[0]), .button_in_1(btn[1]),
      .button_in_2(btn[2]), .button_in_3(btn[3]), .low_voltage(low_voltage),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .data_out(data_out), .led_n(led_n),
      .power_up(power_up));
   // fast rate with format bit: one unit per element
   hcw_rx_model #(.ELEM_CYC(TEU)) i_hcw_rx_model (
      .sys_clk(sys_clk), .data_in(data_out), .rx_word(rx_word), .rx_count(rx_count));
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [66:0] seen, input logic [66:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
      if (n >= 50) begin
         err_total++;
         wrap_up();
      end
   endtask
   // timeout of a hung sequence: count it and close the run
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge sys_clk);
      while (power_up !== 1'b0 && n < 30000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 30000) begin
         err_total++;
         wrap_up();
      end
   endtask
   task automatic shot(input logic [3:0] b);
      base = rx_count;
      btn <= b;
      repeat (5) @(posedge sys_clk);
      btn <= 4'h0;
      wait_idle();
   endtask
   // element length probe: state field read well inside the first word
   task automatic rate_probe(input logic [31:0] c, input logic [2:0] st);
      av(1'b1, hcw_pkg::REG_CTRL, c);
      btn <= 4'h1;
      repeat (5) @(posedge sys_clk);
      btn <= 4'h0;
      repeat (215) @(posedge sys_clk);
      av(1'b0, hcw_pkg::REG_STATUS, 32'h0);
      chk(q[2:0], st);
      wait_idle();
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      rst_b = 1'b0;
      btn = 4'h0;
      low_voltage = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0000_0000;
      err_total = 0;
      comparisons = 0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      av(1'b0, hcw_pkg::REG_CTRL, 32'h0);
      chk(q, 67'h0);
      av(1'b0, 5'h02, 32'h0);
      chk(q, 67'h0);
      av(1'b1, hcw_pkg::REG_STATUS, 32'hFFFF_FFFF);
      av(1'b0, hcw_pkg::REG_STATUS, 32'h0);
      chk(q, 67'h0);
      av(1'b1, hcw_pkg::REG_SERIAL, SER);
      av(1'b1, hcw_pkg::REG_HOP, HOP);
      av(1'b1, hcw_pkg::REG_SEED, SEED);
      av(1'b1, hcw_pkg::REG_SYNC_A, 32'h0000_0010);
      // fast rate, format bit, check bits 2'b10
      av(1'b1, hcw_pkg::REG_CTRL, 32'h0000_1018);
      base = rx_count;
      btn <= 4'h1;
      repeat (5) @(posedge sys_clk);
      btn <= 4'h0;
      av(1'b0, hcw_pkg::REG_PLAIN, 32'h0);
      chk(q, {4'h1, 2'h0, 1'b0, 1'b0, 8'h7B, 16'h0011});
      chk(led_n, 1'b0);
      chk(power_up, 1'b1);
      wait_idle();
      chk(rx_count - base, 16'h0002);
      chk(led_n, 1'b1);
      chk(rx_word, {2'h2, 1'b0, 4'h1, SER[27:0], HOP});
      av(1'b1, hcw_pkg::REG_CTRL, 32'h0000_1058);
      low_voltage <= 1'b1;
      shot(4'h4);
      low_voltage <= 1'b0;
      chk(rx_word, {2'h2, 1'b1, SER, HOP});
      av(1'b1, hcw_pkg::REG_CTRL, 32'h0000_1118);
      shot(4'h9);
      chk(rx_word[31:0], SEED);
      shot(4'h3);
      chk(rx_word[31:0], HOP);
      av(1'b0, hcw_pkg::REG_SYNC_A, 32'h0);
      chk(q, 67'h14);
      av(1'b1, hcw_pkg::REG_CTRL, 32'h0000_101A);
      shot(4'h7);
      shot(4'h8);
      av(1'b0, hcw_pkg::REG_SYNC_A, 32'h0);
      chk(q, 67'h15);
      av(1'b0, hcw_pkg::REG_SYNC_B, 32'h0);
      chk(q, 67'h1);
      av(1'b1, hcw_pkg::REG_CTRL, 32'h0000_101C);
      shot(4'h1);
      chk(rx_count - base, 16'h0001);
      av(1'b1, hcw_pkg::REG_CTRL, 32'h0000_1018);
      base = rx_count;
      btn <= 4'h2;
      repeat (60) @(posedge sys_clk);
      btn <= 4'h6;
      repeat (5) @(posedge sys_clk);
      btn <= 4'h0;
      wait_idle();
      chk(rx_count - base, 16'h0002);
      chk(rx_word[63:60], 4'h6);
      base = rx_count;
      btn <= 4'h1;
      for (int n = 0; n < 9000 && rx_count != base + 16'h0003; n++) @(posedge sys_clk);
      if (rx_count != base + 16'h0003) begin
         err_total++;
         wrap_up();
      end
      // release inside the fourth word: it must still complete
      repeat (300) @(posedge sys_clk);
      btn <= 4'h0;
      wait_idle();
      chk(rx_count - base, 16'h0004);
      // modulation select cancels the format halving: header, not data, at the probe
      rate_probe(32'h0000_1038, 3'h2);
      // slow rate doubles the element again: still in the preamble
      rate_probe(32'h0000_1030, 3'h1);
      wrap_up();
   end
endmodule
`default_nettype wire
